// File: rtl/opcon_button_sync.v
// Button synchroniser and rising-edge pulse generator
`timescale 1ns/1ns
module opcon_button_sync #(
    parameter WIDTH = 10
) (
    // Clock and reset
    input  wire             clock_in,
    input  wire             rst_b_in,
    // Buttons
    input  wire [WIDTH-1:0] button_in,
    output reg  [WIDTH-1:0] press_out
);
    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;
    reg [WIDTH-1:0] prev_reg;

    // First stage feeds only the second stage
    always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_reg  <= {WIDTH{1'b0}};
            sync_reg  <= {WIDTH{1'b0}};
            prev_reg  <= {WIDTH{1'b0}};
            press_out <= {WIDTH{1'b0}};
        end else begin
            meta_reg  <= button_in;
            sync_reg  <= meta_reg;
            prev_reg  <= sync_reg;
            press_out <= sync_reg & ~prev_reg; // RL20
        end
    end
endmodule

// File: rtl/opcon_console.v
// Operator console control: buttons to processor actions, lamps from state
`timescale 1ns/1ns
`include "opcon_defs.vh"
module opcon_console #(
    parameter NLAMP = `OPCON_MONITOR_LAMPS
) (
    // Clock and reset
    input  wire             clock_in,
    input  wire             rst_b_in,
    // Operator buttons, high while pressed
    input  wire             btn_clear_in,
    input  wire             btn_load_in,
    input  wire             btn_rewind_in,
    input  wire             btn_run_in,
    input  wire             btn_stop_in,
    input  wire             btn_kb_request_in,
    input  wire             btn_kb_release_in,
    input  wire             btn_tw_online_in,
    input  wire             btn_tw_offline_in,
    input  wire             buzzer_override_in,
    // Processor state
    input  wire             cpu_executing_in,
    input  wire             cpu_programmed_stop_in,
    input  wire             processor_fault_halt_in,
    input  wire             fault_mode_in,
    input  wire             arm_keyboard_op_in,
    input  wire             block_io_interrupts_op_in,
    input  wire             io_inhibit_clear_in,
    input  wire             char_entered_in,
    // Tape channel status
    input  wire             tape_fault_a_in,
    input  wire             tape_fault_b_in,
    input  wire             tape_load_done_in,
    // Monitor conditions
    input  wire [NLAMP-1:0] abnormal_in,
    input  wire [NLAMP-1:0] periph_offline_in,
    // Processor commands, one-cycle pulses
    output reg              clear_indicators_out,
    output reg              clear_registers_out,
    output reg              start_run_out,
    output reg              set_cont_stop_out,
    output reg              set_kb_request_out,
    output reg              set_kb_release_out,
    output reg              set_tw_interrupt_out,
    output reg              contingency_irq_out,
    // Tape commands
    output reg              tape_read_fwd_out,
    output reg              tape_rewind_out,
    output reg  [3:0]       tape_unit_out,
    output reg              tape_no_ctl_words_out,
    output reg              tape_use_read_mac_out,
    // Typewriter state
    output reg              tw_online_out,
    output reg              keyboard_active_out,
    // Lamps
    output reg              lamp_load_out,
    output reg              lamp_rewind_out,
    output reg              lamp_run_out,
    output reg              lamp_stop_upper_out,
    output reg              lamp_stop_lower_out,
    output reg              lamp_tw_online_out,
    output reg              lamp_tw_offline_out,
    output reg              lamp_io_inhibit_out,
    output reg  [NLAMP-1:0] lamp_monitor_upper_out,
    output reg  [NLAMP-1:0] lamp_monitor_lower_out,
    output reg              buzzer_out
);
    wire [`OPCON_NUM_BUTTONS-1:0] press;
    wire                          p_clear;
    wire                          p_load;
    wire                          p_rewind;
    wire                          p_run;
    wire                          p_stop;
    wire                          p_kb_req;
    wire                          p_kb_rel;
    wire                          p_online;
    wire                          p_offline;
    wire                          stopped;
    wire                          load_ok;
    wire                          kb_req_ok;
    wire                          char_ev;
    reg                           loading_reg;
    reg                           char_prev_reg;
    reg                           loading_next;
    reg                           lamp_load_next;
    reg                           lamp_rewind_next;
    reg                           kb_active_next;
    reg                           tw_online_next;
    reg                           io_inhibit_next;
    wire                          rewind_ok;
    wire                          irq_event;

    // Load sequence states
    localparam LD_IDLE = 1'b0;
    localparam LD_BUSY = 1'b1;

    opcon_button_sync #(
        .WIDTH(`OPCON_NUM_BUTTONS)
    ) u_sync (
        .clock_in  (clock_in),
        .rst_b_in  (rst_b_in),
        .button_in ({1'b0, btn_tw_offline_in, btn_tw_online_in, btn_kb_release_in,
                     btn_kb_request_in, btn_stop_in, btn_run_in, btn_rewind_in,
                     btn_load_in, btn_clear_in}),
        .press_out (press)
    );

    assign p_clear   = press[`OPCON_BTN_CLEAR];
    assign p_load    = press[`OPCON_BTN_LOAD];
    assign p_rewind  = press[`OPCON_BTN_REWIND];
    assign p_run     = press[`OPCON_BTN_RUN];
    assign p_stop    = press[`OPCON_BTN_STOP];
    assign p_kb_req  = press[`OPCON_BTN_KB_REQ];
    assign p_kb_rel  = press[`OPCON_BTN_KB_REL];
    assign p_online  = press[`OPCON_BTN_ONLINE];
    assign p_offline = press[`OPCON_BTN_OFFLINE];

    // Stop lamp lower half is the programmed-stop state
    assign stopped   = cpu_programmed_stop_in; // RL8
    assign load_ok   = p_load & stopped & ~loading_reg; // RL8
    assign rewind_ok = p_rewind & stopped; // RL8
    assign kb_req_ok = p_kb_req & tw_online_out; // RL12
    // Character entry counts once per rising edge of the strobe
    assign char_ev   = char_entered_in & ~char_prev_reg;
    // Every cause that the processor sees as a contingency interrupt
    assign irq_event = p_stop     // RL10
                     | kb_req_ok  // RL12
                     | p_kb_rel   // RL13
                     | char_ev;   // RL19

    // Set-priority flag update: an event that lands in a clearing cycle is kept
    function sticky;
        input cur;
        input set_ev;
        input clr_ev;
        begin
            if (set_ev)
                sticky = 1'b1;
            else if (clr_ev)
                sticky = 1'b0;
            else
                sticky = cur;
        end
    endfunction

    // Typewriter mode: a press acts only from the opposite state, both at once cancel
    function tw_mode;
        input cur;
        input go_online;
        input go_offline;
        begin
            if (go_online && !go_offline)
                tw_mode = 1'b1;
            else if (go_offline && !go_online)
                tw_mode = 1'b0;
            else
                tw_mode = cur;
        end
    endfunction

    // Load sequence: busy from the read command until the block is done or cleared
    always @* begin
        loading_next = loading_reg;
        case (loading_reg)
            LD_IDLE: begin
                if (load_ok)
                    loading_next = LD_BUSY;
            end
            LD_BUSY: begin
                if (tape_load_done_in || p_clear)
                    loading_next = LD_IDLE;
            end
            default: begin
                loading_next = LD_IDLE;
            end
        endcase
    end

    // Fault lamps only set inside the load window, so other reads never light them
    always @* begin
        lamp_load_next   = sticky(lamp_load_out, loading_reg & tape_fault_a_in, p_clear);
        lamp_rewind_next = sticky(lamp_rewind_out, loading_reg & tape_fault_b_in, p_clear);
        kb_active_next   = sticky(keyboard_active_out, arm_keyboard_op_in,
                                  char_ev | p_kb_rel);
        tw_online_next   = tw_mode(tw_online_out, p_online, p_offline);
        io_inhibit_next  = sticky(lamp_io_inhibit_out, block_io_interrupts_op_in,
                                  io_inhibit_clear_in | p_clear);
    end

    // Character strobe history for edge detection
    always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            char_prev_reg <= 1'b0;
        end else begin
            char_prev_reg <= char_entered_in;
        end
    end

    // Processor commands from clear, run and stop presses
    always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            clear_indicators_out <= 1'b0;
            clear_registers_out  <= 1'b0;
            start_run_out        <= 1'b0;
            set_cont_stop_out    <= 1'b0;
        end else begin
            clear_indicators_out <= p_clear; // RL1
            clear_registers_out  <= p_clear; // RL2
            start_run_out        <= p_run; // RL9
            set_cont_stop_out    <= p_stop; // RL10
        end
    end

    // Indicator set pulses and the contingency interrupt that they raise
    always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            set_kb_request_out   <= 1'b0;
            set_kb_release_out   <= 1'b0;
            set_tw_interrupt_out <= 1'b0;
            contingency_irq_out  <= 1'b0;
        end else begin
            set_kb_request_out   <= kb_req_ok; // RL12
            set_kb_release_out   <= p_kb_rel; // RL13
            set_tw_interrupt_out <= char_ev; // RL19
            contingency_irq_out  <= irq_event; // RL10
        end
    end

    // Tape commands; the unit number is fixed, so no press can reach another unit
    always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tape_read_fwd_out     <= 1'b0;
            tape_rewind_out       <= 1'b0;
            tape_unit_out         <= `OPCON_LOAD_UNIT;
            tape_no_ctl_words_out <= 1'b0;
            tape_use_read_mac_out <= 1'b0;
        end else begin
            // One-block read, no control words, base from the read channel counter
            tape_read_fwd_out     <= load_ok; // RL3
            tape_rewind_out       <= rewind_ok; // RL6
            tape_unit_out         <= `OPCON_LOAD_UNIT; // RL3
            tape_no_ctl_words_out <= load_ok; // RL3
            tape_use_read_mac_out <= load_ok; // RL4
        end
    end

    // Load sequence and its fault lamps; the fault set wins over a clear press
    always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            loading_reg     <= LD_IDLE;
            lamp_load_out   <= 1'b0;
            lamp_rewind_out <= 1'b0;
        end else begin
            loading_reg     <= loading_next;
            lamp_load_out   <= lamp_load_next; // RL5
            lamp_rewind_out <= lamp_rewind_next; // RL7
        end
    end

    // Keyboard-active lamp; arming wins over entry or release in one cycle
    always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            keyboard_active_out <= 1'b0;
        end else begin
            keyboard_active_out <= kb_active_next; // RL14
        end
    end

    // Typewriter mode and its lamp halves, plus the I/O inhibit lamp
    always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tw_online_out       <= 1'b0;
            lamp_tw_online_out  <= 1'b0;
            lamp_tw_offline_out <= 1'b1;
            lamp_io_inhibit_out <= 1'b0;
        end else begin
            tw_online_out       <= tw_online_next; // RL15
            lamp_tw_online_out  <= tw_online_next; // RL15
            lamp_tw_offline_out <= ~tw_online_next; // RL15
            lamp_io_inhibit_out <= io_inhibit_next; // RL16
        end
    end

    // Processor state lamps, one cycle behind their inputs
    always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            lamp_run_out        <= 1'b0;
            lamp_stop_upper_out <= 1'b0;
            lamp_stop_lower_out <= 1'b0;
        end else begin
            lamp_run_out        <= cpu_executing_in; // RL9
            lamp_stop_upper_out <= processor_fault_halt_in & fault_mode_in; // RL11
            lamp_stop_lower_out <= cpu_programmed_stop_in; // RL11
        end
    end

    // Monitor panel and buzzer; the override only silences, the lamps stay lit
    always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            lamp_monitor_upper_out <= {NLAMP{1'b0}};
            lamp_monitor_lower_out <= {NLAMP{1'b0}};
            buzzer_out             <= 1'b0;
        end else begin
            lamp_monitor_upper_out <= abnormal_in; // RL17
            lamp_monitor_lower_out <= periph_offline_in; // RL18
            buzzer_out             <= (|abnormal_in) & ~buzzer_override_in; // RL17
        end
    end
endmodule

// File: rtl/opcon_defs.vh
// Constants for the operator console control block
// Behaviour
// RL1 - Clear button resets all error, contingency, I/O, sense, interrupt-mode indicators.
// RL2 - Clear also zeroes control counter, index, arithmetic registers, address counters.
// RL3 - Load button commands tape unit 0 to read one block forward, no control words.
// RL4 - Console load stores data from basic read channel address counter, normally zero.
// RL5 - Load lamp lights on first-class read fault during load, until clear.
// RL6 - Rewind button starts rewind of tape unit 0 without interlock.
// RL7 - Rewind lamp lights on second-class read fault during load, until clear.
// RL8 - Load and rewind are ignored unless processor is in programmed stop.
// RL9 - Run starts execution at control counter; lamp lit while executing.
// RL10 - Stop button sets contingency-stop indicator, raising contingency interrupt.
// RL11 - Stop lamp upper half on fault halt with mode set; lower on programmed stop.
// RL12 - Keyboard request sets indicator and interrupt only while typewriter is on-line.
// RL13 - Keyboard release sets indicator, raises interrupt, turns off keyboard-active lamp.
// RL14 - Keyboard-active lamp on by arm instruction, off on character entry or release.
// RL15 - On-line/off-line buttons switch only from opposite state; lamp halves show state.
// RL16 - I/O-inhibit lamp lit while inhibit indicator set after block instruction.
// RL17 - Monitor upper halves and buzzer follow abnormal conditions; override silences buzzer.
// RL18 - Monitor lower half lit while its channel's peripheral is off-line.
// RL19 - Character entry deactivates keyboard, sets typewriter indicator, raises interrupt.
// RL20 - Each button is synchronised and edge-detected into one single-cycle pulse.
`ifndef OPCON_DEFS_VH
`define OPCON_DEFS_VH
`define OPCON_NUM_BUTTONS   10
`define OPCON_BTN_CLEAR     0
`define OPCON_BTN_LOAD      1
`define OPCON_BTN_REWIND    2
`define OPCON_BTN_RUN       3
`define OPCON_BTN_STOP      4
`define OPCON_BTN_KB_REQ    5
`define OPCON_BTN_KB_REL    6
`define OPCON_BTN_ONLINE    7
`define OPCON_BTN_OFFLINE   8
`define OPCON_BTN_SPARE     9
`define OPCON_LOAD_UNIT     4'h0
`define OPCON_MONITOR_LAMPS 10
`endif

// File: sim/opcon_console_monitor.sv
// Concurrent checks on the operator console ports
`timescale 1ns/1ns
module opcon_console_monitor #(
    parameter NLAMP = 10
) (
    // Clock, reset, inputs and the typewriter mode output
    input wire             clock_in, rst_b_in, buzzer_override_in,
    input wire             cpu_executing_in, cpu_programmed_stop_in, tw_online_out,
    input wire [NLAMP-1:0] abnormal_in, periph_offline_in,
    // Outputs, with the fault halt and fault mode inputs
    input wire             clear_indicators_out, clear_registers_out, start_run_out,
    input wire             set_cont_stop_out, set_kb_request_out, set_kb_release_out,
    input wire             set_tw_interrupt_out, contingency_irq_out, tape_read_fwd_out,
    input wire             tape_rewind_out, tape_no_ctl_words_out, tape_use_read_mac_out,
    input wire [3:0]       tape_unit_out,
    input wire             lamp_run_out, lamp_stop_lower_out, buzzer_out,
    input wire             processor_fault_halt_in, fault_mode_in, lamp_stop_upper_out,
    input wire [NLAMP-1:0] lamp_monitor_upper_out, lamp_monitor_lower_out
);
    reg up_reg;
    // Lagged lamps still hold reset values at the first edge after release
    always @(posedge clock_in or negedge rst_b_in)
        if (!rst_b_in) up_reg <= 1'b0; else up_reg <= 1'b1;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    a_clear_pair: assert property (clear_indicators_out == clear_registers_out)
        else $error("clear pulses differ");
    a_load_cmd: assert property (tape_read_fwd_out |-> tape_unit_out == 4'h0
        && tape_no_ctl_words_out && tape_use_read_mac_out) else $error("bad load command");
    a_rewind_unit: assert property (tape_rewind_out |-> tape_unit_out == 4'h0)
        else $error("rewind unit not zero");
    a_load_gated: assert property (tape_read_fwd_out || tape_rewind_out
        |-> $past(cpu_programmed_stop_in)) else $error("tape command outside stop");
    a_irq_cause: assert property (contingency_irq_out == (set_cont_stop_out
        || set_kb_request_out || set_kb_release_out || set_tw_interrupt_out))
        else $error("interrupt without cause");
    a_kb_online: assert property (set_kb_request_out |-> $past(tw_online_out))
        else $error("request while off-line");
    a_run_single: assert property (start_run_out |=> !start_run_out)
        else $error("run pulse too long");
    a_run_lamp: assert property (up_reg |-> lamp_run_out == $past(cpu_executing_in))
        else $error("run lamp wrong");
    a_stop_lamp: assert property (up_reg |-> lamp_stop_lower_out ==
        $past(cpu_programmed_stop_in)) else $error("stop lamp wrong");
    a_stop_upper: assert property (up_reg |-> lamp_stop_upper_out ==
        ($past(processor_fault_halt_in) && $past(fault_mode_in)))
        else $error("stop lamp upper half wrong");
    a_monitor_lamps: assert property (up_reg |-> lamp_monitor_upper_out ==
        $past(abnormal_in) && lamp_monitor_lower_out == $past(periph_offline_in))
        else $error("monitor lamps wrong");
    a_buzzer_follow: assert property (up_reg |-> buzzer_out ==
        ($past(|abnormal_in) && !$past(buzzer_override_in))) else $error("buzzer wrong");
endmodule

// File: sim/opcon_console_tb_top.sv
// Self-checking bench for the operator console control block
`timescale 1ns/1ns
module opcon_console_tb_top;
    reg         clock_in = 1'b0;
    reg         rst_b_in = 1'b0;
    reg  [8:0]  btn = 9'h000;
    reg  [3:0]  op = 4'h0;
    reg  [1:0]  err_sel = 2'h0;
    reg         buzzer_override_in = 1'b0, fault_mode_in = 1'b0, processor_fault_halt_in = 1'b0;
    reg  [9:0]  abnormal_in = 10'h000, periph_offline_in = 10'h000;
    wire        btn_clear_in = btn[0], btn_load_in = btn[1], btn_rewind_in = btn[2];
    wire        btn_run_in = btn[3], btn_stop_in = btn[4], btn_kb_request_in = btn[5];
    wire        btn_kb_release_in = btn[6], btn_tw_online_in = btn[7], btn_tw_offline_in = btn[8];
    wire        arm_keyboard_op_in = op[0], block_io_interrupts_op_in = op[1];
    wire        io_inhibit_clear_in = op[2], char_entered_in = op[3];
    wire        cpu_executing_in, cpu_programmed_stop_in, tape_fault_a_in, tape_fault_b_in;
    wire        tape_load_done_in, clear_indicators_out, clear_registers_out, start_run_out;
    wire        set_cont_stop_out, set_kb_request_out, set_kb_release_out, set_tw_interrupt_out;
    wire        contingency_irq_out, tape_read_fwd_out, tape_rewind_out, tape_no_ctl_words_out;
    wire        tape_use_read_mac_out, tw_online_out, keyboard_active_out, lamp_load_out;
    wire        lamp_rewind_out, lamp_run_out, lamp_stop_upper_out, lamp_stop_lower_out;
    wire        lamp_tw_online_out, lamp_tw_offline_out, lamp_io_inhibit_out, buzzer_out;
    wire [3:0]  tape_unit_out;
    wire [9:0]  lamp_monitor_upper_out, lamp_monitor_lower_out;
    wire [7:0]  pv = {set_tw_interrupt_out, set_kb_release_out, set_kb_request_out,
                      set_cont_stop_out, start_run_out, tape_rewind_out, tape_read_fwd_out,
                      clear_indicators_out};
    logic [31:0] cnt [8];
    int         n_mismatch = 0, comparisons = 0;
    opcon_console   i_dut (.*);
    opcon_cpu_model i_cpu (.*);
    initial forever #5 clock_in = ~clock_in;
    always @(posedge clock_in) begin
        for (int k = 0; k < 8; k++) cnt[k] += pv[k];
        if (rst_b_in)
            {buzzer_override_in, fault_mode_in, processor_fault_halt_in,
             periph_offline_in, abnormal_in} <= 23'($urandom);
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask
    // Hold a button for six cycles, then count pulses on one command line
    task automatic press(input int b, input int k, input int exp);
        @(negedge clock_in) foreach (cnt[i]) cnt[i] = 0;
        @(posedge clock_in) btn[b] <= 1'b1;
        repeat (6) @(posedge clock_in);
        btn[b] <= 1'b0;
        repeat (6) @(posedge clock_in);
        #1 check(cnt[k], exp);
    endtask
    task automatic strobe(input int w);
        @(posedge clock_in) op[w] <= 1'b1;
        @(posedge clock_in) op[w] <= 1'b0;
        repeat (3) @(posedge clock_in);
        #1;
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clock_in);
        n_mismatch++;
        complete_run;
    end
    initial begin
        void'($urandom(58));
        repeat (8) @(posedge clock_in);
        rst_b_in <= 1'b1;
        press(0, 0, 1);
        for (int e = 1; e < 3; e++) begin
            err_sel = 2'(e);
            press(1, 1, 1);
            check({lamp_rewind_out, lamp_load_out}, e);
            press(0, 0, 1);
            check({lamp_rewind_out, lamp_load_out}, 0);
        end
        err_sel = 2'h0;
        press(2, 2, 1);
        $display("test tape done");
        press(3, 3, 1);
        check(lamp_run_out, 1);
        press(1, 1, 0);
        press(2, 2, 0);
        repeat (40) @(posedge clock_in);
        press(4, 4, 1);
        $display("test run done");
        press(5, 5, 0);
        press(7, 0, 0);
        check({lamp_tw_online_out, tw_online_out}, 3);
        press(7, 0, 0);
        check(tw_online_out, 1);
        press(5, 5, 1);
        strobe(0);
        check(keyboard_active_out, 1);
        strobe(3);
        check(keyboard_active_out, 0);
        strobe(0);
        press(6, 6, 1);
        check(keyboard_active_out, 0);
        press(8, 0, 0);
        check({lamp_tw_offline_out, tw_online_out}, 2);
        strobe(1);
        check(lamp_io_inhibit_out, 1);
        strobe(2);
        check(lamp_io_inhibit_out, 0);
        $display("test keyboard done");
        complete_run;
    end
endmodule
bind opcon_console opcon_console_monitor #(.NLAMP(NLAMP)) i_mon (.*);

// File: sim/opcon_cpu_model.sv
// Processor and tape channel stand-in facing the console block
`timescale 1ns/1ns
module opcon_cpu_model (
    // Clock and reset
    input  wire       clock_in,
    input  wire       rst_b_in,
    // Commands from the console, fault class chosen by the bench
    input  wire       start_run_out,
    input  wire       tape_read_fwd_out,
    input  wire [1:0] err_sel,
    // Processor and tape status back to the console
    output wire       cpu_executing_in,
    output wire       cpu_programmed_stop_in,
    output wire       tape_fault_a_in,
    output wire       tape_fault_b_in,
    output reg        tape_load_done_in
);
    reg [5:0] run_reg;
    reg [2:0] tape_reg;
    // Short program that ends in a wait, so the machine returns to programmed stop
    assign cpu_executing_in       = run_reg != 6'h00;
    assign cpu_programmed_stop_in = !cpu_executing_in;
    // Fault lines only carry a class while a block is being read
    assign tape_fault_a_in        = (tape_reg != 3'h0) && err_sel[0];
    assign tape_fault_b_in        = (tape_reg != 3'h0) && err_sel[1];
    always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            run_reg           <= 6'h00;
            tape_reg          <= 3'h0;
            tape_load_done_in <= 1'b0;
        end else begin
            if (start_run_out)
                run_reg <= 6'h32;
            else if (run_reg != 6'h00)
                run_reg <= run_reg - 6'h01;
            if (tape_read_fwd_out)
                tape_reg <= 3'h6;
            else if (tape_reg != 3'h0)
                tape_reg <= tape_reg - 3'h1;
            tape_load_done_in <= tape_reg == 3'h1;
        end
    end
endmodule
